// ### dv/gpio_board.sv
// Board model: external drivers and the pull-up on the pins
`timescale 1ns/1ps
module gpio_board (
	// From the block
	input wire logic [4:0] i_pu,
	input wire logic [7:0] i_drv,
	input wire logic [7:0] i_oe,
	// Board drivers
	input wire logic [4:0] i_ext9,
	input wire logic [7:0] i_extb,
	// Pin levels
	output logic [4:0] o_p9,
	output logic [7:0] o_pb
);
	// A connected pull-up lifts the line high
	assign o_p9 = i_pu | i_ext9;
	// Driven bits follow the latch, released bits follow the board
	assign o_pb = (i_oe & i_drv) | (~i_oe & i_extb);
endmodule : gpio_board

// ### dv/gpio_chk.sv
// Port-level assertions for the GPIO block
`timescale 1ns/1ps
module gpio_chk (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire gpio_pkg::addr_t i_addr,
	input wire gpio_pkg::data_t i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire gpio_pkg::data_t o_rdata,
	input wire logic [4:0] i_port9_direction,
	input wire logic [4:0] i_port9_output_type,
	input wire logic [4:0] o_port9_pullup_on,
	input wire logic [7:0] i_portb_output_type,
	input wire logic [7:0] o_portb_pin,
	input wire logic [7:0] o_portb_pin_oe
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	sequence latch_wr;
		i_wr && i_addr == 12'h00b;
	endsequence
	sequence latch_rd;
		i_rd && i_addr == 12'h00b;
	endsequence
	// Push-pull output bits of the 5-bit port, zero elsewhere
	logic [4:0] p9_pp;
	assign p9_pp = i_port9_direction & ~i_port9_output_type;
	latch_set_a: assert property (
		latch_wr |=> o_portb_pin == $past(i_wdata))
		else $error("latch write lost");
	latch_keep_a: assert property (
		!(i_wr && i_addr == 12'h00b) |=> $stable(o_portb_pin))
		else $error("latch moved without write");
	latch_back_a: assert property (
		latch_rd |=> o_rdata == $past(o_portb_pin))
		else $error("latch read wrong");
	idle_zero_a: assert property (
		!i_rd |=> o_rdata == 8'h00)
		else $error("read data not idle");
	p9_mask_a: assert property (
		i_rd && i_addr == 12'h016 |=>
		(o_rdata & {3'h7, $past(p9_pp)}) == 8'h00)
		else $error("push-pull bit read high");
	pu_upper_a: assert property (
		i_rd && i_addr == 12'hf30 |=> o_rdata[7:5] == 3'h0)
		else $error("pull-up upper bits set");
	pu_gate_a: assert property (
		(o_port9_pullup_on & p9_pp) == 5'h00)
		else $error("pull-up on push-pull output");
	od_release_a: assert property (
		(o_portb_pin_oe & o_portb_pin & i_portb_output_type) == 8'h00)
		else $error("open drain drives high");
endmodule : gpio_chk
bind gpio_pullup_readback_portb gpio_chk u_chk (.*);

// ### dv/gpio_pullup_readback_portb_tb.sv
// Directed bench for the GPIO block
`timescale 1ns/1ps
module gpio_pullup_readback_portb_tb;
	logic i_clk = 0, i_reset = 1, i_wr = 0, i_rd = 0;
	gpio_pkg::addr_t i_addr = 0;
	gpio_pkg::data_t i_wdata = 0, o_rdata, pbo, oe, pb, tb = 0, eb = 0;
	logic [4:0] d9 = 0, t9 = 0, e9 = 0, pu, p9;
	int n_fail = 0, checked = 0, cyc = 0;
	initial forever #50 i_clk = ~i_clk;
	gpio_pullup_readback_portb uut (.i_clk, .i_reset, .i_addr, .i_wdata,
		.i_wr, .i_rd, .o_rdata, .i_port9_direction(d9),
		.i_port9_output_type(t9), .i_port9_pin(p9), .o_port9_pullup_on(pu),
		.i_portb_output_type(tb), .i_portb_pin(pb), .o_portb_pin(pbo),
		.o_portb_pin_oe(oe));
	gpio_board board (.i_pu(pu), .i_drv(pbo), .i_oe(oe), .i_ext9(e9),
		.i_extb(eb), .o_p9(p9), .o_pb(pb));
	task summarize;
		$display("checked %0d failed %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize
	task chk(input gpio_pkg::data_t g, input gpio_pkg::data_t e);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task wr(input gpio_pkg::addr_t a, input gpio_pkg::data_t d);
		@(posedge i_clk);
		i_wr <= 1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 0;
	endtask : wr
	task rd(input gpio_pkg::addr_t a, input gpio_pkg::data_t e);
		@(posedge i_clk);
		i_rd <= 1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 0;
		@(negedge i_clk);
		chk(o_rdata, e);
	endtask : rd
	// Cut a hang short
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 1000) begin
			n_fail++;
			summarize();
		end
	end
	initial begin
		repeat (16) @(posedge i_clk);
		i_reset <= 0;
		rd(12'h00b, 8'h00);
		rd(12'hf25, 8'h00);
		rd(12'hf30, 8'h00);
		$display("reset values done");
		eb <= 8'h3c;
		wr(12'h00b, 8'ha5);
		wr(12'hf25, 8'hff);
		rd(12'h00b, 8'ha5);
		rd(12'hf25, 8'hff);
		rd(12'h018, 8'h00);
		chk(pbo, 8'ha5);
		tb <= 8'hff;
		repeat (3) @(posedge i_clk);
		rd(12'h018, 8'h24);
		tb <= 8'h00;
		wr(12'hf25, 8'h0f);
		repeat (3) @(posedge i_clk);
		rd(12'h018, 8'h30);
		chk(oe, 8'h0f);
		$display("second port done");
		d9 <= 5'h03;
		t9 <= 5'h01;
		e9 <= 5'h02;
		wr(12'hf30, 8'hff);
		rd(12'hf30, 8'h1f);
		chk({3'h0, pu}, 8'h1d);
		repeat (3) @(posedge i_clk);
		rd(12'h016, 8'h1d);
		wr(12'h123, 8'hff);
		rd(12'h123, 8'h00);
		$display("five-bit port done");
		summarize();
	end
endmodule : gpio_pullup_readback_portb_tb

// ### src/gpio_defs.svh
// Register offsets, widths and reset values for the GPIO block
`ifndef GPIO_DEFS_SVH
`define GPIO_DEFS_SVH

`define GPIO_ADDR_W 12
`define GPIO_DATA_W 8
`define PORT9_W 5
`define PORTB_W 8

`define PORTB_OUTPUT_LATCH_OFS 12'h00b
`define PORT9_PIN_READBACK_OFS 12'h016
`define PORTB_PIN_READBACK_OFS 12'h018
`define PORTB_DIRECTION_OFS 12'hf25
`define PORT9_PULLUP_ENABLE_OFS 12'hf30

`define PORTB_OUTPUT_LATCH_RST 8'h00
`define PORTB_DIRECTION_RST 8'h00
`define PORT9_PULLUP_ENABLE_RST 5'h00

`endif

// ### src/gpio_pkg.sv
// Shared types for the GPIO block
`include "gpio_defs.svh"
package gpio_pkg;
	// One register data word
	typedef logic [`GPIO_DATA_W-1:0] data_t;
	// One register address
	typedef logic [`GPIO_ADDR_W-1:0] addr_t;
endpackage : gpio_pkg

// ### src/gpio_pullup_readback_portb.sv
// GPIO logic: 5-bit port pull-ups and readback, full 8-bit second port
`timescale 1ns/1ps
`include "gpio_defs.svh"
module gpio_pullup_readback_portb (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Register port
	input wire gpio_pkg::addr_t i_addr,
	input wire gpio_pkg::data_t i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output gpio_pkg::data_t o_rdata,
	// 5-bit port mode, from its own registers elsewhere
	input wire logic [`PORT9_W-1:0] i_port9_direction,
	input wire logic [`PORT9_W-1:0] i_port9_output_type,
	// 5-bit port pins
	input wire logic [`PORT9_W-1:0] i_port9_pin,
	output logic [`PORT9_W-1:0] o_port9_pullup_on,
	// Second port output type (no register of its own)
	input wire logic [`PORTB_W-1:0] i_portb_output_type,
	// Second port pins
	input wire logic [`PORTB_W-1:0] i_portb_pin,
	output logic [`PORTB_W-1:0] o_portb_pin,
	output logic [`PORTB_W-1:0] o_portb_pin_oe
);
	logic [`PORTB_W-1:0] portb_output_latch_q; // Second port latch
	logic [`PORTB_W-1:0] portb_output_latch_d;
	logic [`PORTB_W-1:0] portb_direction_q; // 1 = output
	logic [`PORTB_W-1:0] portb_direction_d;
	logic [`PORT9_W-1:0] port9_pullup_enable_q; // Pull-up request
	logic [`PORT9_W-1:0] port9_pullup_enable_d;
	gpio_pkg::data_t rdata_q; // Read data, one cycle after strobe
	gpio_pkg::data_t rdata_d;
	logic [`PORT9_W-1:0] port9_readback; // Gated 5-bit pin levels
	logic [`PORTB_W-1:0] portb_readback; // Gated 8-bit pin levels

	// Widen a 5-bit field to a data word, upper bits zero
	function automatic gpio_pkg::data_t pad5(
		input logic [`PORT9_W-1:0] v);
		pad5 = {{(`GPIO_DATA_W-`PORT9_W){1'b0}}, v};
	endfunction : pad5

	// 5-bit port readback, direction and type gated
	pin_readback #(.W(`PORT9_W)) u_port9_rb (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_pin(i_port9_pin),
		.i_direction(i_port9_direction),
		.i_output_type(i_port9_output_type),
		.o_readback(port9_readback)
	);

	// Second port readback, same gating per bit
	pin_readback #(.W(`PORTB_W)) u_portb_rb (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_pin(i_portb_pin),
		.i_direction(portb_direction_q),
		.i_output_type(i_portb_output_type),
		.o_readback(portb_readback)
	);

	// Register writes; writes to other addresses are ignored
	always_comb begin
		portb_output_latch_d = portb_output_latch_q;
		portb_direction_d = portb_direction_q;
		port9_pullup_enable_d = port9_pullup_enable_q;
		if (i_wr) begin
			case (i_addr)
				`PORTB_OUTPUT_LATCH_OFS: begin
					portb_output_latch_d = i_wdata;
				end
				`PORTB_DIRECTION_OFS: begin
					portb_direction_d = i_wdata;
				end
				`PORT9_PULLUP_ENABLE_OFS: begin
					// Upper bits dropped on purpose
					port9_pullup_enable_d = i_wdata[`PORT9_W-1:0];
				end
				default: begin
					// Unmapped: nothing changes
				end
			endcase
		end
	end

	// Register reads; the answer is held for exactly one cycle
	always_comb begin
		rdata_d = '0;
		if (i_rd) begin
			case (i_addr)
				`PORTB_OUTPUT_LATCH_OFS: begin
					rdata_d = portb_output_latch_q;
				end
				`PORTB_DIRECTION_OFS: begin
					rdata_d = portb_direction_q;
				end
				`PORT9_PULLUP_ENABLE_OFS: begin
					rdata_d = pad5(port9_pullup_enable_q);
				end
				`PORT9_PIN_READBACK_OFS: begin
					rdata_d = pad5(port9_readback);
				end
				`PORTB_PIN_READBACK_OFS: begin
					rdata_d = portb_readback;
				end
				default: begin
					// Unmapped reads answer zero
					rdata_d = '0;
				end
			endcase
		end
	end

	// State registers
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			portb_output_latch_q <= `PORTB_OUTPUT_LATCH_RST;
			portb_direction_q <= `PORTB_DIRECTION_RST;
			port9_pullup_enable_q <= `PORT9_PULLUP_ENABLE_RST;
			rdata_q <= '0;
		end else begin
			portb_output_latch_q <= portb_output_latch_d;
			portb_direction_q <= portb_direction_d;
			port9_pullup_enable_q <= port9_pullup_enable_d;
			rdata_q <= rdata_d;
		end
	end

	assign o_rdata = rdata_q;

	// Pull-up only where the pin is input or open drain; a push-pull
	// output would just fight its own resistor and waste current
	assign o_port9_pullup_on = port9_pullup_enable_q
		& (~i_port9_direction | i_port9_output_type);

	// Each bit drives its latch level when an output; open drain
	// releases the pin on a 1 so the external pull-up sets the high
	assign o_portb_pin = portb_output_latch_q;
	assign o_portb_pin_oe = portb_direction_q
		& (~i_portb_output_type | ~portb_output_latch_q);
endmodule : gpio_pullup_readback_portb

// ### src/pin_readback.sv
// Pin synchroniser and direction-gated readback for one port
`timescale 1ns/1ps
module pin_readback #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Raw pins and port mode
	input wire logic [W-1:0] i_pin,
	input wire logic [W-1:0] i_direction,
	input wire logic [W-1:0] i_output_type,
	// Gated, synchronised pin levels
	output logic [W-1:0] o_readback
);
	logic [W-1:0] meta_q; // First stage, read only by the second
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q; // Second stage, safe to use
	logic [W-1:0] sync_d;

	// Pass-through: pins are outside this clock domain
	always_comb begin
		meta_d = i_pin;
		sync_d = meta_q;
	end

	// Two-flop synchroniser
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	// Push-pull outputs read zero; inputs and open drain show the pin
	assign o_readback = sync_q & (~i_direction | i_output_type);
endmodule : pin_readback
